// ### rtl/spi_port_pkg.sv
// Shared constants of the serial register port
package spi_port_pkg;
    // Interface-select strap: width and the code of its upper two bits for serial mode
    localparam int HOST_SEL_W = 3;
    localparam logic [1:0] SEL_SPI = 2'h1;
    // Register and frame layout: one command word, then data
    localparam int REG_W = 16;
    localparam int ADDR_W = 15;
    localparam int WORD_W = ADDR_W + REG_W;
    localparam int RW_POS = 15;
    localparam logic RW_READ = 1'h1;
    // Bit counter and the edges at which the frame changes phase
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_CMD_LAST = 6'h0f;
    localparam logic [CNT_W-1:0] CNT_WR_LAST = 6'h1f;
    localparam logic [CNT_W-1:0] CNT_RD_LOAD = 6'h17;
    localparam logic [CNT_W-1:0] CNT_RD_FIRST = 6'h18;
    localparam logic [CNT_W-1:0] CNT_RD_END = 6'h28;
    localparam logic [CNT_W-1:0] CNT_MAX = 6'h3f;
    // Write buffer depth
    localparam int FIFO_DEPTH = 16;
endpackage

// ### rtl/fifo_if.sv
// Valid/ready carrier between the port logic and its write buffer
`timescale 1ns/1ps
interface fifo_if #(
    parameter int W = 31
);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    // The buffer's own view
    modport store (
        input in_valid, in_data, out_ready,
        output in_ready, out_valid, out_data
    );
    // The port logic's view
    modport user (
        output in_valid, in_data, out_ready,
        input in_ready, out_valid, out_data
    );
endinterface

// ### rtl/word_fifo.sv
// Single-clock word FIFO with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
    parameter int W = 31,
    parameter int DEPTH = 16
) (
    input wire logic i_mclk,     // System clock
    input wire logic i_reset_n,  // Synchronous reset, active low
    fifo_if.store io_q           // Push and pop sides
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] count;
    } fifo_state_t;

    fifo_state_t state_ff;
    fifo_state_t nxt_state;
    logic push;
    logic pop;

    // Full and empty come from the count, so they never lie
    assign io_q.in_ready = (state_ff.count != (AW+1)'(DEPTH));
    assign io_q.out_valid = (state_ff.count != '0);
    assign io_q.out_data = state_ff.mem[state_ff.rd_ptr];
    assign push = io_q.in_valid && io_q.in_ready;
    assign pop = io_q.out_valid && io_q.out_ready;

    // Pointer wrap relies on DEPTH being a power of two
    always_comb begin
        nxt_state = state_ff;
        if (push) begin
            nxt_state.mem[state_ff.wr_ptr] = io_q.in_data;
            nxt_state.wr_ptr = state_ff.wr_ptr + AW'(1);
        end
        if (pop) begin
            nxt_state.rd_ptr = state_ff.rd_ptr + AW'(1);
        end
        if (push && !pop) begin
            nxt_state.count = state_ff.count + (AW+1)'(1);
        end else if (pop && !push) begin
            nxt_state.count = state_ff.count - (AW+1)'(1);
        end
    end

    // Storage is cleared too, so a read of an empty slot is never unknown
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end
endmodule

// ### rtl/spi_register_port.sv
// Serial register port: SPI slave framing, clock crossing and register requests
`timescale 1ns/1ps
// How it works
// [R1] Serial pins act only in serial strap mode
// [R2] Accesses happen only while chip select low
// [R3] Board ties address latch enable high
// [R4] Serial clock is input only, master-driven
// [R5] All command, address, data arrive on input
// [R6] Read data returned on serial output pin
// [R7] Phase strap picks leading or trailing capture
// [R8] Polarity strap picks idle-low or idle-high clock
// [R9] Interrupt is active-low open-drain in serial mode
// [R10] Interrupt low while unmasked source is active
// [R11] Registers are sixteen bits, host-addressed
// [R12] Chip select high aborts, idles output
// [R13] Command carries direction, address; MSB first
module spi_register_port #(
    parameter int DEPTH = spi_port_pkg::FIFO_DEPTH
) (
    input wire logic i_mclk,                                   // System clock
    input wire logic i_reset_n,                                // Sync reset, low
    input wire logic [spi_port_pkg::HOST_SEL_W-1:0] i_host_interface_select, // Strap
    input wire logic i_cpha,                                   // Clock phase strap
    input wire logic i_cpol,                                   // Clock polarity strap
    input wire logic i_sclk,                                   // Serial clock pin
    input wire logic i_cs_n,                                   // Chip select, low
    input wire logic i_sdi,                                    // Serial data in
    output logic o_sdo,                                        // Serial data out
    input wire logic i_irq_active,                             // Unmasked source active
    output logic o_int_n_o,                                    // Interrupt pin level
    output logic o_int_n_oe,                                   // Interrupt pin enable
    output logic o_spi_mode,                                   // Serial mode active
    output logic o_wr_valid,                                   // Write request
    output logic [spi_port_pkg::ADDR_W-1:0] o_wr_addr,         // Write address
    output logic [spi_port_pkg::REG_W-1:0] o_wr_data,          // Write data
    input wire logic i_wr_ready,                               // Write taken
    output logic o_rd_valid,                                   // Read request
    output logic [spi_port_pkg::ADDR_W-1:0] o_rd_addr,         // Read address
    input wire logic i_rd_ack,                                 // Read answered
    input wire logic [spi_port_pkg::REG_W-1:0] i_rd_data       // Read data
);
    localparam int AW = spi_port_pkg::ADDR_W;
    localparam int RW = spi_port_pkg::REG_W;
    localparam int WW = spi_port_pkg::WORD_W;
    localparam int CW = spi_port_pkg::CNT_W;

    // System-clock state
    typedef struct packed {
        logic [spi_port_pkg::HOST_SEL_W-1:0] sel_s1;
        logic [spi_port_pkg::HOST_SEL_W-1:0] sel_s2;
        logic ph_s1;
        logic ph_s2;
        logic pol_s1;
        logic pol_s2;
        logic spi_mode;
        logic link_rst_n;
        logic wtg_s1;
        logic wtg_s2;
        logic wtg_seen;
        logic rtg_s1;
        logic rtg_s2;
        logic rtg_seen;
        logic wr_pend;
        logic [WW-1:0] wr_word;
        logic wr_valid;
        logic [AW-1:0] wr_addr;
        logic [RW-1:0] wr_data;
        logic rd_valid;
        logic [AW-1:0] rd_addr;
        logic [RW-1:0] rd_data;
        logic rd_ack_tgl;
        logic int_oe;
    } sys_state_t;

    // Link state kept across frames, cleared only by the link reset
    typedef struct packed {
        logic wtg;
        logic rtg;
        logic [WW-1:0] wr_hold;
        logic [AW-1:0] rd_addr_hold;
        logic ack_s1;
        logic ack_s2;
    } keep_state_t;

    // Link state that lives for one frame only
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic [RW-1:0] shin;
        logic is_read;
        logic [AW-1:0] cmd_addr;
        logic [RW-1:0] txsh;
    } frame_state_t;

    sys_state_t sys_ff;
    sys_state_t nxt_sys;
    keep_state_t keep_ff;
    keep_state_t nxt_keep;
    frame_state_t frm_ff;
    frame_state_t nxt_frm;
    logic sdo_ff;
    logic nxt_sdo;
    logic sck_sample;
    logic frm_rst_n;
    logic [RW-1:0] rx_word;
    logic fifo_idle;

    fifo_if #(.W(WW)) wq ();

    // Write buffer between the link and the register bus
    word_fifo #(
        .W(WW),
        .DEPTH(DEPTH)
    ) u_wr_fifo (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .io_q(wq)
    );

    // Fold both straps into one sampling clock; a strap change mid-frame may glitch it
    assign sck_sample = i_sclk ^ sys_ff.pol_s2 ^ sys_ff.ph_s2; // [R4] [R7] [R8]

    // Frame logic is held in reset while chip select is high or the port is off
    assign frm_rst_n = ~i_cs_n & sys_ff.link_rst_n; // [R2] [R12]

    // Word formed by the bit arriving on this edge
    assign rx_word = {frm_ff.shin[RW-2:0], i_sdi}; // [R5]

    // Helper: sample edge index is within the read data phase
    function automatic logic in_rd_data(input logic [CW-1:0] c);
        in_rd_data = (c >= spi_port_pkg::CNT_RD_FIRST) && (c < spi_port_pkg::CNT_RD_END);
    endfunction

    // Per-edge bit counter, input shifter and output shifter
    always_comb begin
        nxt_frm = frm_ff;
        nxt_frm.shin = rx_word; // [R5]
        if (frm_ff.cnt != spi_port_pkg::CNT_MAX) begin
            nxt_frm.cnt = frm_ff.cnt + CW'(1);
        end
        if (frm_ff.cnt == spi_port_pkg::CNT_CMD_LAST) begin
            nxt_frm.is_read = (rx_word[spi_port_pkg::RW_POS] == spi_port_pkg::RW_READ); // [R13]
            nxt_frm.cmd_addr = rx_word[AW-1:0]; // [R13]
        end
        // Data is only loaded if the answer made it across in time
        if (frm_ff.is_read && frm_ff.cnt == spi_port_pkg::CNT_RD_LOAD) begin
            if (keep_ff.ack_s2 == keep_ff.rtg) begin
                nxt_frm.txsh = sys_ff.rd_data; // [R11]
            end else begin
                nxt_frm.txsh = '0;
            end
        end else if (in_rd_data(frm_ff.cnt)) begin
            nxt_frm.txsh = {frm_ff.txsh[RW-2:0], 1'h0}; // [R13]
        end
    end

    // Capture of completed commands into the crossing holds
    always_comb begin
        nxt_keep = keep_ff;
        nxt_keep.ack_s1 = sys_ff.rd_ack_tgl;
        nxt_keep.ack_s2 = keep_ff.ack_s1;
        if (frm_ff.cnt == spi_port_pkg::CNT_CMD_LAST &&
            rx_word[spi_port_pkg::RW_POS] == spi_port_pkg::RW_READ) begin
            nxt_keep.rd_addr_hold = rx_word[AW-1:0]; // [R13]
            nxt_keep.rtg = ~keep_ff.rtg;
        end
        if (frm_ff.cnt == spi_port_pkg::CNT_WR_LAST && !frm_ff.is_read) begin
            nxt_keep.wr_hold = {frm_ff.cmd_addr, rx_word}; // [R11]
            nxt_keep.wtg = ~keep_ff.wtg;
        end
    end

    // Output bit changes on the edge opposite to capture
    always_comb begin
        nxt_sdo = 1'h0;
        if (frm_ff.is_read && in_rd_data(frm_ff.cnt)) begin
            nxt_sdo = frm_ff.txsh[RW-1]; // [R6]
        end
    end

    // Frame registers: chip select high aborts the transfer at once
    always_ff @(posedge sck_sample or negedge frm_rst_n) begin
        if (!frm_rst_n) begin
            frm_ff <= '0; // [R12]
        end else begin
            frm_ff <= nxt_frm;
        end
    end

    // Crossing holds survive the frame so the system side can read them
    always_ff @(posedge sck_sample or negedge sys_ff.link_rst_n) begin
        if (!sys_ff.link_rst_n) begin
            keep_ff <= '0;
        end else begin
            keep_ff <= nxt_keep;
        end
    end

    // Output is idle low outside a frame
    always_ff @(negedge sck_sample or negedge frm_rst_n) begin
        if (!frm_rst_n) begin
            sdo_ff <= 1'h0; // [R12]
        end else begin
            sdo_ff <= nxt_sdo; // [R6]
        end
    end

    // Buffer ports: push the pending write, drain into the output stage
    assign wq.in_valid = sys_ff.wr_pend;
    assign wq.in_data = sys_ff.wr_word;
    assign wq.out_ready = !sys_ff.wr_valid || i_wr_ready;
    assign fifo_idle = !wq.out_valid && !sys_ff.wr_valid && !sys_ff.wr_pend;

    // System side: straps, crossings, request ordering and interrupt
    always_comb begin
        nxt_sys = sys_ff;
        nxt_sys.sel_s1 = i_host_interface_select;
        nxt_sys.sel_s2 = sys_ff.sel_s1;
        nxt_sys.ph_s1 = i_cpha;
        nxt_sys.ph_s2 = sys_ff.ph_s1;
        nxt_sys.pol_s1 = i_cpol;
        nxt_sys.pol_s2 = sys_ff.pol_s1;
        nxt_sys.spi_mode = (sys_ff.sel_s2[2:1] == spi_port_pkg::SEL_SPI); // [R1]
        nxt_sys.link_rst_n = sys_ff.spi_mode; // [R1]
        nxt_sys.wtg_s1 = keep_ff.wtg;
        nxt_sys.wtg_s2 = sys_ff.wtg_s1;
        nxt_sys.rtg_s1 = keep_ff.rtg;
        nxt_sys.rtg_s2 = sys_ff.rtg_s1;
        // A new write waits while the previous one is refused by a full buffer
        if (sys_ff.wr_pend && wq.in_ready) begin
            nxt_sys.wr_pend = 1'h0;
        end
        // Link reset clears the toggles; follow it so no phantom request appears
        if (!sys_ff.link_rst_n) begin
            nxt_sys.wtg_seen = 1'h0;
            nxt_sys.rtg_seen = 1'h0;
            nxt_sys.rd_ack_tgl = 1'h0;
        end
        if ((sys_ff.wtg_s2 != sys_ff.wtg_seen) && !sys_ff.wr_pend && sys_ff.link_rst_n) begin
            nxt_sys.wtg_seen = sys_ff.wtg_s2;
            nxt_sys.wr_word = keep_ff.wr_hold; // [R2]
            nxt_sys.wr_pend = 1'h1;
        end
        // Output stage of the write bus
        if (wq.out_ready) begin
            nxt_sys.wr_valid = wq.out_valid;
            nxt_sys.wr_addr = wq.out_data[WW-1:RW];
            nxt_sys.wr_data = wq.out_data[RW-1:0];
        end
        // Reads wait for earlier writes so they see the written value
        if ((sys_ff.rtg_s2 != sys_ff.rtg_seen) && !sys_ff.rd_valid && fifo_idle &&
            sys_ff.link_rst_n) begin
            nxt_sys.rtg_seen = sys_ff.rtg_s2;
            nxt_sys.rd_addr = keep_ff.rd_addr_hold;
            nxt_sys.rd_valid = 1'h1; // [R2]
        end
        if (sys_ff.rd_valid && i_rd_ack) begin
            nxt_sys.rd_valid = 1'h0;
            nxt_sys.rd_data = i_rd_data; // [R11]
            nxt_sys.rd_ack_tgl = ~sys_ff.rd_ack_tgl;
        end
        // Open drain: pull low only, never drive high
        nxt_sys.int_oe = sys_ff.spi_mode && i_irq_active; // [R9] [R10]
    end

    // System-clock register
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            sys_ff <= '0;
        end else begin
            sys_ff <= nxt_sys;
        end
    end

    // Outputs straight from flip-flops, except the interrupt level, which is tied low
    assign o_sdo = sdo_ff;
    assign o_int_n_o = 1'h0; // [R9]
    assign o_int_n_oe = sys_ff.int_oe;
    assign o_spi_mode = sys_ff.spi_mode;
    assign o_wr_valid = sys_ff.wr_valid;
    assign o_wr_addr = sys_ff.wr_addr;
    assign o_wr_data = sys_ff.wr_data;
    assign o_rd_valid = sys_ff.rd_valid;
    assign o_rd_addr = sys_ff.rd_addr;
endmodule

// ### verification/spi_register_port_checker.sv
// Concurrent checks on the serial register port pins
`timescale 1ns/1ps
module spi_register_port_checker (
    input wire logic i_mclk, // Clock
    input wire logic i_reset_n, // Reset
    input wire logic [spi_port_pkg::HOST_SEL_W-1:0] i_host_interface_select, // Strap
    input wire logic i_cs_n, // Select
    input wire logic o_sdo, // Serial out
    input wire logic i_irq_active, // Source
    input wire logic o_int_n_o, // Pin level
    input wire logic o_int_n_oe, // Pin enable
    input wire logic o_spi_mode, // Mode
    input wire logic o_wr_valid, // Write
    input wire logic [spi_port_pkg::ADDR_W-1:0] o_wr_addr, // Address
    input wire logic [spi_port_pkg::REG_W-1:0] o_wr_data, // Data
    input wire logic i_wr_ready, // Taken
    input wire logic o_rd_valid, // Read
    input wire logic [spi_port_pkg::ADDR_W-1:0] o_rd_addr, // Address
    input wire logic i_rd_ack // Answered
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    // Requests left waiting by the register side
    sequence s_wr_wait;
        o_wr_valid && !i_wr_ready;
    endsequence
    sequence s_rd_wait;
        o_rd_valid && !i_rd_ack;
    endsequence
    // Strap must outlast the two sync stages before mode follows
    AST_MODE_ON:
        assert property ((i_host_interface_select[2:1] == spi_port_pkg::SEL_SPI)[*5]
            |=> o_spi_mode) else $error("serial mode not entered");
    AST_MODE_OFF:
        assert property ((i_host_interface_select[2:1] != spi_port_pkg::SEL_SPI)[*5]
            |=> !o_spi_mode) else $error("serial mode not left");
    AST_INT_LEVEL:
        assert property (o_int_n_o == 1'b0) else $error("interrupt pin not low level");
    AST_INT_EN:
        assert property (o_int_n_oe == $past(o_spi_mode && i_irq_active))
            else $error("interrupt enable wrong");
    AST_SDO_IDLE:
        assert property (i_cs_n && $past(i_cs_n, 2) |-> !o_sdo) else $error("sdo not idle");
    AST_WR_HOLD:
        assert property (s_wr_wait |=> o_wr_valid && $stable(o_wr_addr) && $stable(o_wr_data))
            else $error("write request dropped");
    AST_RD_HOLD:
        assert property (s_rd_wait |=> o_rd_valid && $stable(o_rd_addr))
            else $error("read request dropped");
    AST_RD_AFTER_WR:
        assert property (o_rd_valid |-> !o_wr_valid) else $error("read overtook write");
endmodule
bind spi_register_port spi_register_port_checker u_chk (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_host_interface_select(i_host_interface_select),
    .i_cs_n(i_cs_n), .o_sdo(o_sdo), .i_irq_active(i_irq_active), .o_int_n_o(o_int_n_o),
    .o_int_n_oe(o_int_n_oe), .o_spi_mode(o_spi_mode), .o_wr_valid(o_wr_valid),
    .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .i_wr_ready(i_wr_ready),
    .o_rd_valid(o_rd_valid), .o_rd_addr(o_rd_addr), .i_rd_ack(i_rd_ack)
);

// ### verification/spi_master_model.sv
// Behavioural serial bus master for the port's pins
`timescale 1ns/1ps
module spi_master_model (
    input wire logic i_cpol, // Polarity in use
    input wire logic i_cpha, // Phase in use
    input wire logic i_sdo, // Data from the port
    output logic o_sclk, // Serial clock
    output logic o_cs_n, // Select, active low
    output logic o_sdi // Data to the port
);
    // Address latch pin is not modelled; the board holds it high
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi = 1'b0;
    end
    // One frame of n bits, MSB first; 32 ns clock only inside the frame
    task automatic frame(input logic [39:0] tx, input int n, output logic [39:0] rx);
        rx = '0;
        o_sclk = i_cpol;
        #50;
        o_cs_n = 1'b0;
        if (!i_cpha) o_sdi = tx[n-1];
        #16;
        for (int i = n - 1; i >= 0; i--) begin
            o_sclk = ~i_cpol;
            if (i_cpha) o_sdi = tx[i];
            else rx = {rx[38:0], i_sdo};
            #16;
            o_sclk = i_cpol;
            if (i_cpha) rx = {rx[38:0], i_sdo};
            else if (i > 0) o_sdi = tx[i-1];
            #16;
        end
        o_cs_n = 1'b1;
        o_sdi = ~o_sdi; // No pull on the line, so show a changed level
    endtask
endmodule

// ### verification/spi_register_port_tb_top.sv
// Bench: master model on the pins, register responder behind the port
`timescale 1ns/1ps
module spi_register_port_tb_top;
    localparam int DEPTH = spi_port_pkg::FIFO_DEPTH;
    logic mclk, reset_n, cpha, cpol, sclk, cs_n, sdi, sdo, irq, int_o, int_oe, spi_mode;
    logic wr_valid, wr_ready, rd_valid, rd_ack, stall;
    logic [2:0] sel;
    logic [spi_port_pkg::ADDR_W-1:0] wr_addr, rd_addr;
    logic [spi_port_pkg::REG_W-1:0] wr_data, rd_data;
    logic [15:0] mem [32];
    logic [30:0] wq [$];
    logic [39:0] rx;
    int error_cnt, cmp_count;
    spi_register_port DUT (.i_mclk(mclk), .i_reset_n(reset_n), .i_host_interface_select(sel),
        .i_cpha(cpha), .i_cpol(cpol), .i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi), .o_sdo(sdo),
        .i_irq_active(irq), .o_int_n_o(int_o), .o_int_n_oe(int_oe), .o_spi_mode(spi_mode),
        .o_wr_valid(wr_valid), .o_wr_addr(wr_addr), .o_wr_data(wr_data), .i_wr_ready(wr_ready),
        .o_rd_valid(rd_valid), .o_rd_addr(rd_addr), .i_rd_ack(rd_ack), .i_rd_data(rd_data));
    spi_master_model u_master (.i_cpol(cpol), .i_cpha(cpha), .i_sdo(sdo), .o_sclk(sclk),
        .o_cs_n(cs_n), .o_sdi(sdi));
    // Register side: ready a cycle late so every write waits at least once, longer while stall is high
    always @(posedge mclk) begin
        wr_ready <= wr_valid && !wr_ready && !stall;
        rd_ack <= rd_valid && !rd_ack;
        rd_data <= mem[rd_addr[4:0]];
        if (wr_valid && wr_ready) begin
            mem[wr_addr[4:0]] <= wr_data;
            wq.push_back({wr_addr, wr_data});
        end
    end
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic give_verdict();
        if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wait_wr(input int n);
        for (int k = 0; k < 4000 && wq.size() < n; k++) @(posedge mclk);
        if (wq.size() < n) begin
            chk("write count", 32'(n), 32'(wq.size()));
            give_verdict();
        end
    endtask
    task automatic wr(input logic [14:0] a, input logic [15:0] d);
        u_master.frame({9'h0, a, d}, 32, rx);
    endtask
    task automatic rd(input logic [14:0] a);
        u_master.frame({1'b1, a, 24'h0}, 40, rx);
    endtask
    // Every clock mode: write, then read the word back
    task automatic t_modes();
        logic [14:0] a;
        logic [15:0] d;
        for (int m = 0; m < 4; m++) begin
            @(posedge mclk);
            cpol <= m[1];
            cpha <= m[0];
            a = 15'h4010 | 15'(m);
            d = 16'hc35a ^ 16'(m * 16'h1111);
            cyc(8);
            wq.delete();
            wr(a, d);
            wait_wr(1);
            chk("write word", 32'({a, d}), 32'(wq[0]));
            rd(a);
            chk("read data", 32'(d), 32'(rx[15:0]));
        end
    endtask
    // Partial frame cut by select must leave nothing behind
    task automatic t_abort();
        wq.delete();
        u_master.frame({20'h0, 1'b0, 15'h0003, 4'hf}, 20, rx);
        wr(15'h0004, 16'h1234);
        wait_wr(1);
        cyc(40);
        chk("writes after abort", 32'h1, 32'(wq.size()));
        chk("word after abort", {1'b0, 15'h0004, 16'h1234}, 32'(wq[0]));
    endtask
    // Send DEPTH writes while the register side stalls; one sits in the output stage, the rest in the buffer
    task automatic t_burst();
        @(posedge mclk);
        stall <= 1'b1;
        wq.delete();
        for (int i = 0; i < DEPTH; i++) wr(15'h0100 + 15'(i), 16'h0f00 + 16'(i));
        cyc(20);
        chk("stalled writes", 32'h0, 32'(wq.size()));
        @(posedge mclk);
        stall <= 1'b0;
        wait_wr(DEPTH);
        for (int i = 0; i < DEPTH; i++)
            chk("burst word", 32'({15'h0100 + 15'(i), 16'h0f00 + 16'(i)}), 32'(wq[i]));
    endtask
    // Interrupt pin, then the strap taken out of serial mode
    task automatic t_irq_strap();
        @(posedge mclk);
        irq <= 1'b1;
        cyc(3);
        chk("int enable", 32'h1, 32'(int_oe));
        chk("int level", 32'h0, 32'(int_o));
        @(posedge mclk);
        irq <= 1'b0;
        cyc(3);
        chk("int released", 32'h0, 32'(int_oe));
        @(posedge mclk);
        sel <= 3'h4;
        irq <= 1'b1;
        cyc(8);
        chk("mode off", 32'h0, 32'(spi_mode));
        chk("int off", 32'h0, 32'(int_oe));
        wq.delete();
        wr(15'h0005, 16'h5555);
        rd(15'h4010);
        cyc(40);
        chk("writes off", 32'h0, 32'(wq.size()));
        chk("read off", 32'h0, 32'(rx[15:0]));
        @(posedge mclk);
        sel <= 3'h3;
        cyc(8);
        chk("mode back", 32'h1, 32'(spi_mode));
    endtask
    initial begin
        reset_n = 1'b0;
        sel = 3'h2;
        cpha = 1'b0;
        cpol = 1'b0;
        irq = 1'b0;
        stall = 1'b0;
        wr_ready = 1'b0;
        rd_ack = 1'b0;
        rd_data = '0;
        error_cnt = 0;
        cmp_count = 0;
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        cyc(12);
        chk("serial mode", 32'h1, 32'(spi_mode));
        t_modes();
        t_abort();
        t_burst();
        t_irq_strap();
        give_verdict();
    end
endmodule
